// ==== hdl/torque_mode_speed_limiter.sv ====
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module torque_mode_speed_limiter
    import speed_limit_pkg::*;
#(
    parameter int SPEED_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic runCmd,
    input wire logic reverseCmd,
    input wire logic torqueModeEn,
    input wire logic signed [SPEED_W-1:0] speedFb,
    input wire logic signed [15:0] voltRef,
    input wire logic signed [15:0] currentRef,
    input wire logic signed [15:0] torqueRefIn,
    output logic signed [15:0] torqueRefOut,
    output logic suppressing
);
    if (SPEED_W < 2 || SPEED_W > WIN_W - 1) begin : g_bad_width
        $error("SPEED_W must lie in 2..19");
    end

    typedef struct packed {
        logic [1:0] source;
        logic level;
        logic [4:0] curFn;
        logic signed [7:0] limit;
        logic [6:0] margin;
        logic [7:0] gain;
        logic refused;
        logic waitReq;
        logic [31:0] rdData;
        logic limitFwd;
        logic signed [WIN_W-1:0] winLo;
        logic signed [WIN_W-1:0] winHi;
        logic signed [15:0] torqueOut;
        logic supp;
    } lim_state_t;

    lim_state_t s_q;
    lim_state_t s_d;
    logic [1:0] pinSync;
    logic running;
    logic reverse;
    logic signed [WIN_W-1:0] voltScaled;
    logic signed [WIN_W-1:0] rawLimit;
    logic signed [WIN_W-1:0] limitMag;
    logic signed [WIN_W-1:0] marginCnt;
    logic signed [WIN_W-1:0] speedExt;
    logic limitFwdNow;
    logic over;
    logic signed [15:0] suppress;
    logic signed [WIN_W-1:0] torqueSum;
    logic busTake;
    logic busCommit;
    logic wrOk;
    logic [7:0] wrByte;

    sync_two_flop #(
        .WIDTH(2)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .asyncIn({reverseCmd, runCmd}),
        .syncOut(pinSync)
    );

    assign running = pinSync[0];
    assign reverse = pinSync[1];
    assign speedExt = WIN_W'(speedFb);

    window_suppress u_suppress (
        .speed(speedExt),
        .winLo(s_q.winLo),
        .winHi(s_q.winHi),
        .gain(s_q.gain),
        .over(over),
        .suppress(suppress)
    );

    always_comb begin
        // unipolar level drops negative readings of the voltage input
        if (s_q.level == 1'b0 && voltRef < 0) begin
            voltScaled = '0;
        end else begin
            voltScaled = WIN_W'(voltRef);
        end
        if (s_q.source == SRC_ANALOG) begin
            rawLimit = voltScaled;
            if (s_q.curFn == CURFN_FREQREF) begin
                rawLimit = voltScaled + WIN_W'(currentRef);
            end
        end else begin
            rawLimit = WIN_W'(s_q.limit) * WIN_W'(PCT_COUNTS);
        end
        // sign of the limit against run direction picks the limited side
        limitFwdNow = (rawLimit >= 0) ^ reverse;
        limitMag = (rawLimit < 0) ? -rawLimit : rawLimit;
        marginCnt = WIN_W'($signed({1'b0, s_q.margin})) * WIN_W'(PCT_COUNTS);
        torqueSum = WIN_W'(torqueRefIn) + WIN_W'(suppress);
    end

    assign busTake = (read || write) && s_q.waitReq;
    assign busCommit = (read || write) && !s_q.waitReq;
    assign wrByte = writedata[7:0];

    always_comb begin
        s_d = s_q;
        wrOk = 1'b0;
        // opposite side limit is zero, margin widens both sides
        if (limitFwdNow) begin
            s_d.winLo = -marginCnt;
            s_d.winHi = limitMag + marginCnt;
        end else begin
            s_d.winLo = -(limitMag + marginCnt);
            s_d.winHi = marginCnt;
        end
        s_d.limitFwd = limitFwdNow;
        if (torqueModeEn && over) begin
            if (torqueSum > 32767) begin
                s_d.torqueOut = 16'sh7FFF;
            end else if (torqueSum < -32768) begin
                s_d.torqueOut = -16'sh8000;
            end else begin
                s_d.torqueOut = torqueSum[15:0];
            end
            s_d.supp = 1'b1;
        end else begin
            s_d.torqueOut = torqueRefIn;
            s_d.supp = 1'b0;
        end
        // one wait cycle: answer loads, then the master's sampling edge commits
        s_d.waitReq = !busTake;
        if (busTake) begin
            s_d.rdData = '0;
            unique case (address)
                OFS_SOURCE: s_d.rdData = 32'(s_q.source);
                OFS_LEVEL: s_d.rdData = 32'(s_q.level);
                OFS_CURFN: s_d.rdData = 32'(s_q.curFn);
                OFS_LIMIT: s_d.rdData = 32'(signed'(s_q.limit));
                OFS_MARGIN: s_d.rdData = 32'(s_q.margin);
                OFS_GAIN: s_d.rdData = 32'(s_q.gain);
                OFS_STATUS: s_d.rdData = 32'({s_q.refused, reverse, running, s_q.supp,
                    s_q.limitFwd});
                OFS_WINLO: s_d.rdData = 32'(signed'(s_q.winLo));
                default: s_d.rdData = '0;
            endcase
        end
        if (busCommit && write && byteenable[0]) begin
            // settings other than gain are frozen while the drive runs
            unique case (address)
                OFS_SOURCE: wrOk = !running && (wrByte[7:2] == '0) &&
                    (wrByte[1:0] == SRC_ANALOG || wrByte[1:0] == SRC_STORED);
                OFS_LEVEL: wrOk = !running && (wrByte[7:1] == '0);
                OFS_CURFN: wrOk = !running && (wrByte[7:5] == '0) && (wrByte[4:0] >= CURFN_MIN);
                OFS_LIMIT: wrOk = !running && ($signed(wrByte) >= LIMIT_MIN) &&
                    ($signed(wrByte) <= LIMIT_MAX);
                OFS_MARGIN: wrOk = !running && (wrByte <= 8'(MARGIN_MAX));
                OFS_GAIN: wrOk = 1'b1;
                default: wrOk = 1'b0;
            endcase
            if (wrOk) begin
                unique case (address)
                    OFS_SOURCE: s_d.source = wrByte[1:0];
                    OFS_LEVEL: s_d.level = wrByte[0];
                    OFS_CURFN: s_d.curFn = wrByte[4:0];
                    OFS_LIMIT: s_d.limit = $signed(wrByte);
                    OFS_MARGIN: s_d.margin = wrByte[6:0];
                    OFS_GAIN: s_d.gain = wrByte;
                    default: s_d.gain = s_q.gain;
                endcase
            end
            if (address == OFS_STATUS && wrByte[ST_REFUSED]) begin
                s_d.refused = 1'b0;
            end
            // a refused settings write sets the flag; status writes only clear it
            if (!wrOk && address != OFS_STATUS && address <= OFS_GAIN) begin
                s_d.refused = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
            s_q.source <= RST_SOURCE;
            s_q.level <= RST_LEVEL;
            s_q.curFn <= RST_CURFN;
            s_q.limit <= RST_LIMIT;
            s_q.margin <= RST_MARGIN;
            s_q.gain <= RST_GAIN;
            s_q.waitReq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign readdata = s_q.rdData;
    assign waitrequest = s_q.waitReq;
    assign torqueRefOut = s_q.torqueOut;
    assign suppressing = s_q.supp;

    AST_PASS_THROUGH: assert property (@(posedge sys_clk) disable iff (reset)
        (!over || !torqueModeEn) |=> torqueRefOut == $past(torqueRefIn))
        else $error("torque changed inside the speed window");

    AST_SUPPRESS_FWD: assert property (@(posedge sys_clk) disable iff (reset)
        (torqueModeEn && speedExt > s_q.winHi && torqueRefIn < 16'sh7000) |=>
        (torqueRefOut < $past(torqueRefIn) || $past(s_q.gain) == 8'h00) && suppressing)
        else $error("forward overspeed not opposed");

    AST_SUPPRESS_REV: assert property (@(posedge sys_clk) disable iff (reset)
        (torqueModeEn && speedExt < s_q.winLo && torqueRefIn > -16'sh7000 && s_q.gain != 0)
        |=> torqueRefOut > $past(torqueRefIn))
        else $error("reverse overspeed not opposed");

    AST_SOURCE_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_q.source == SRC_ANALOG || s_q.source == SRC_STORED)
        else $error("limit source out of range");

    AST_LIMIT_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_q.limit >= LIMIT_MIN && s_q.limit <= LIMIT_MAX)
        else $error("stored limit out of range");

    AST_MARGIN_RANGE: assert property (@(posedge sys_clk) disable iff (reset)
        s_q.margin <= MARGIN_MAX)
        else $error("margin out of range");

    AST_FROZEN_RUN: assert property (@(posedge sys_clk) disable iff (reset)
        (running && write && !s_q.waitReq && byteenable[0] &&
        (address == OFS_SOURCE || address == OFS_LIMIT || address == OFS_MARGIN)) |=>
        $stable(s_q.source) && $stable(s_q.limit) && $stable(s_q.margin) && s_q.refused)
        else $error("setting changed while running");

    AST_WIN_FWD: assert property (@(posedge sys_clk) disable iff (reset)
        s_q.limitFwd |-> s_q.winLo <= 0 && s_q.winHi >= 0 && s_q.winHi >= -s_q.winLo &&
        s_q.winLo == -(WIN_W'($past(s_q.margin)) * WIN_W'(PCT_COUNTS)))
        else $error("forward window malformed");

    AST_DIRECTION: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_STORED && s_q.limit > 0 && !reverse) ##1 $stable(s_q.limit)
        && $stable(reverse) |-> s_q.limitFwd)
        else $error("limited direction wrong");

    AST_ANALOG_VOLT: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_ANALOG && s_q.curFn != CURFN_FREQREF && voltRef >= 0) |->
        limitMag == WIN_W'(voltRef))
        else $error("analog limit not taken from voltage input");

    AST_ANALOG_SUM: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_ANALOG && s_q.curFn == CURFN_FREQREF && voltRef >= 0 &&
        currentRef >= 0) |-> limitMag == WIN_W'(voltRef) + WIN_W'(currentRef))
        else $error("analog limit is not voltage plus current");

    AST_UNIPOLAR: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_ANALOG && !s_q.level && voltRef < 0 &&
        s_q.curFn != CURFN_FREQREF) |-> limitMag == 0)
        else $error("unipolar level passed a negative voltage");

    AST_STORED_SCALE: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_STORED && s_q.limit >= 0) |->
        limitMag == WIN_W'(s_q.limit) * WIN_W'(PCT_COUNTS))
        else $error("stored limit scaled wrongly");

    AST_REV_STORED: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_STORED && s_q.limit < 0 && !reverse) |=>
        !s_q.limitFwd)
        else $error("negative stored limit not reversed");

    AST_REV_ANALOG: assert property (@(posedge sys_clk) disable iff (reset)
        (s_q.source == SRC_ANALOG && s_q.level && s_q.curFn != CURFN_FREQREF &&
        voltRef < 0 && !reverse) |=> !s_q.limitFwd)
        else $error("negative analog limit not reversed");

    AST_ZERO_OPPOSITE: assert property (@(posedge sys_clk) disable iff (reset)
        ($past(s_q.margin) == 7'h00) |->
        (s_q.limitFwd ? s_q.winLo == 0 : s_q.winHi == 0))
        else $error("opposite side limit is not zero");

    AST_WIN_REV: assert property (@(posedge sys_clk) disable iff (reset)
        (!$past(reset) && !s_q.limitFwd) |-> s_q.winLo <= -s_q.winHi &&
        s_q.winHi == WIN_W'($past(s_q.margin)) * WIN_W'(PCT_COUNTS))
        else $error("reverse window malformed");

    AST_LIMIT_REFUSE: assert property (@(posedge sys_clk) disable iff (reset)
        (busCommit && write && byteenable[0] && address == OFS_LIMIT &&
        $signed(wrByte) > LIMIT_MAX) |=> s_q.refused && $stable(s_q.limit))
        else $error("out of range limit accepted");

    AST_SOURCE_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
        (busCommit && write && byteenable[0] && address == OFS_SOURCE && !running &&
        wrByte == 8'h02) |=> s_q.source == SRC_STORED)
        else $error("stored source not selected");

    AST_LEVEL_REFUSE: assert property (@(posedge sys_clk) disable iff (reset)
        (busCommit && write && byteenable[0] && address == OFS_LEVEL &&
        wrByte[7:1] != 7'h00) |=> s_q.refused && $stable(s_q.level))
        else $error("illegal level code accepted");

    AST_SUPP_FLAG: assert property (@(posedge sys_clk) disable iff (reset)
        (torqueModeEn && over) |=> suppressing)
        else $error("suppression flag missing outside window");

    AST_NO_SUPP: assert property (@(posedge sys_clk) disable iff (reset)
        (!torqueModeEn || !over) |=> !suppressing)
        else $error("suppression flag set inside window");
endmodule

// ==== hdl/speed_limit_pkg.sv ====
package speed_limit_pkg;
    localparam logic [4:0] OFS_SOURCE = 5'h00;
    localparam logic [4:0] OFS_LEVEL = 5'h04;
    localparam logic [4:0] OFS_CURFN = 5'h08;
    localparam logic [4:0] OFS_LIMIT = 5'h0C;
    localparam logic [4:0] OFS_MARGIN = 5'h10;
    localparam logic [4:0] OFS_GAIN = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    localparam logic [4:0] OFS_WINLO = 5'h1C;

    localparam logic [1:0] SRC_ANALOG = 2'h1;
    localparam logic [1:0] SRC_STORED = 2'h2;
    localparam logic [4:0] CURFN_FREQREF = 5'h1F;
    localparam logic [4:0] CURFN_MIN = 5'h01;
    localparam logic signed [7:0] LIMIT_MAX = 8'sh78;
    localparam logic signed [7:0] LIMIT_MIN = -8'sh78;
    localparam logic [6:0] MARGIN_MAX = 7'h78;

    localparam logic [1:0] RST_SOURCE = 2'h1;
    localparam logic RST_LEVEL = 1'b0;
    localparam logic [4:0] RST_CURFN = 5'h1F;
    localparam logic signed [7:0] RST_LIMIT = 8'sh00;
    localparam logic [6:0] RST_MARGIN = 7'h0A;
    localparam logic [7:0] RST_GAIN = 8'h10;

    // speed and analog counts per percent of maximum frequency
    localparam int PCT_COUNTS = 100;
    localparam int GAIN_SHIFT = 4;
    localparam int WIN_W = 20;

    localparam int ST_FWD = 0;
    localparam int ST_SUPP = 1;
    localparam int ST_RUN = 2;
    localparam int ST_REV = 3;
    localparam int ST_REFUSED = 4;
endpackage

// ==== hdl/sync_two_flop.sv ====
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int WIDTH = 2
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb begin
        s_d.meta = asyncIn;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign syncOut = s_q.stable;
endmodule

// ==== hdl/window_suppress.sv ====
`timescale 1ns/1ps
module window_suppress
    import speed_limit_pkg::*;
(
    input wire logic signed [speed_limit_pkg::WIN_W-1:0] speed,
    input wire logic signed [speed_limit_pkg::WIN_W-1:0] winLo,
    input wire logic signed [speed_limit_pkg::WIN_W-1:0] winHi,
    input wire logic [7:0] gain,
    output logic over,
    output logic signed [15:0] suppress
);
    logic signed [WIN_W:0] excess;
    logic signed [WIN_W+9:0] prod;
    logic signed [WIN_W+9:0] scaled;

    always_comb begin
        excess = '0;
        over = 1'b0;
        if (speed > winHi) begin
            // forward overspeed: push torque backward
            excess = (WIN_W+1)'(winHi) - (WIN_W+1)'(speed);
            over = 1'b1;
        end else if (speed < winLo) begin
            excess = (WIN_W+1)'(winLo) - (WIN_W+1)'(speed);
            over = 1'b1;
        end
        prod = (WIN_W+10)'(excess) * $signed({1'b0, gain});
        scaled = prod >>> GAIN_SHIFT;
        // saturate so a runaway never wraps into an aiding torque
        if (scaled > 32767) begin
            suppress = 16'sh7FFF;
        end else if (scaled < -32767) begin
            suppress = -16'sh7FFF;
        end else begin
            suppress = scaled[15:0];
        end
    end
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import speed_limit_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic runCmd = 1'b0;
    logic reverseCmd = 1'b0;
    logic torqueModeEn = 1'b0;
    logic signed [15:0] speedFb = 16'h0000;
    logic signed [15:0] voltRef = 16'h0000;
    logic signed [15:0] currentRef = 16'h0000;
    logic signed [15:0] torqueRefIn = 16'h0000;
    logic signed [15:0] torqueRefOut;
    logic suppressing;
    logic [31:0] rd;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #2 sys_clk = ~sys_clk;

    torque_mode_speed_limiter #(.SPEED_W(16)) torque_mode_speed_limiter_i (
        .sys_clk(sys_clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .runCmd(runCmd), .reverseCmd(reverseCmd),
        .torqueModeEn(torqueModeEn), .speedFb(speedFb), .voltRef(voltRef),
        .currentRef(currentRef), .torqueRefIn(torqueRefIn), .torqueRefOut(torqueRefOut),
        .suppressing(suppressing)
    );

    task automatic end_of_test;
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // whole run needs a few hundred cycles; ceiling leaves wide slack
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request stands until an edge samples waitrequest low; data is taken at that edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        writedata <= d;
        byteenable <= 4'h1;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic regChk(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        chk({24'h00_0000, rd[7:0]}, {24'h00_0000, exp});
    endtask

    task automatic refusedChk(input logic exp);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, rd[4]}, {31'h0000_0000, exp});
        bus(1'b1, OFS_STATUS, 32'h0000_0010);
    endtask

    task automatic winChk(input logic signed [19:0] exp);
        bus(1'b0, OFS_WINLO, 32'h0000_0000);
        chk({12'h000, rd[19:0]}, {12'h000, exp});
    endtask

    task automatic cfg(input logic [7:0] src, lvl, cur, lim, mar);
        bus(1'b1, OFS_SOURCE, {24'h00_0000, src});
        bus(1'b1, OFS_LEVEL, {24'h00_0000, lvl});
        bus(1'b1, OFS_CURFN, {24'h00_0000, cur});
        bus(1'b1, OFS_LIMIT, {24'h00_0000, lim});
        bus(1'b1, OFS_MARGIN, {24'h00_0000, mar});
    endtask

    // settle time covers the pin synchroniser plus window and output stages
    task automatic drive(input logic run, rev, mode, input logic signed [15:0] spd, vr, cr);
        @(posedge sys_clk);
        runCmd <= run;
        reverseCmd <= rev;
        torqueModeEn <= mode;
        speedFb <= spd;
        voltRef <= vr;
        currentRef <= cr;
        torqueRefIn <= 16'h03E8;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic outChk(input logic signed [15:0] expOut, input logic expSup);
        chk({16'h0000, torqueRefOut}, {16'h0000, expOut});
        chk({31'h0000_0000, suppressing}, {31'h0000_0000, expSup});
    endtask

    task automatic t_reset;
        regChk(OFS_SOURCE, 8'h01);
        regChk(OFS_LEVEL, 8'h00);
        regChk(OFS_CURFN, 8'h1F);
        regChk(OFS_LIMIT, 8'h00);
        regChk(OFS_MARGIN, 8'h0A);
        regChk(OFS_GAIN, 8'h10);
    endtask

    task automatic t_refuse;
        bus(1'b1, OFS_SOURCE, 32'h0000_0003);
        regChk(OFS_SOURCE, 8'h01);
        refusedChk(1'b1);
        refusedChk(1'b0);
        bus(1'b1, OFS_LEVEL, 32'h0000_0002);
        refusedChk(1'b1);
        bus(1'b1, OFS_LIMIT, 32'h0000_0079);
        refusedChk(1'b1);
        bus(1'b1, OFS_LIMIT, 32'h0000_0087);
        refusedChk(1'b1);
        bus(1'b1, OFS_LIMIT, 32'h0000_0078);
        regChk(OFS_LIMIT, 8'h78);
        bus(1'b1, OFS_MARGIN, 32'h0000_0079);
        regChk(OFS_MARGIN, 8'h0A);
        bus(1'b1, OFS_MARGIN, 32'h0000_0078);
        regChk(OFS_MARGIN, 8'h78);
        bus(1'b1, OFS_SOURCE, 32'h0000_0002);
        regChk(OFS_SOURCE, 8'h02);
    endtask

    task automatic t_stored;
        cfg(8'h02, 8'h00, 8'h1F, 8'h32, 8'h00);
        drive(1'b1, 1'b0, 1'b1, 16'h13EC, 16'h0000, 16'h0000);
        outChk(16'h0384, 1'b1);
        winChk(20'h0_0000);
        drive(1'b1, 1'b0, 1'b1, 16'h09C4, 16'h0000, 16'h0000);
        outChk(16'h03E8, 1'b0);
        drive(1'b1, 1'b0, 1'b0, 16'h13EC, 16'h0000, 16'h0000);
        outChk(16'h03E8, 1'b0);
        drive(1'b1, 1'b1, 1'b1, -16'sh13EC, 16'h0000, 16'h0000);
        outChk(16'h044C, 1'b1);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk({30'h0000_0000, rd[3:2]}, 32'h0000_0003);
        drive(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
        cfg(8'h02, 8'h00, 8'h1F, 8'hCE, 8'h00);
        drive(1'b1, 1'b0, 1'b1, -16'sh13EC, 16'h0000, 16'h0000);
        outChk(16'h044C, 1'b1);
        drive(1'b1, 1'b0, 1'b1, 16'h0064, 16'h0000, 16'h0000);
        outChk(16'h0384, 1'b1);
    endtask

    task automatic t_margin;
        drive(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
        cfg(8'h02, 8'h00, 8'h1F, 8'h00, 8'h32);
        drive(1'b1, 1'b0, 1'b1, -16'sh1324, 16'h0000, 16'h0000);
        outChk(16'h03E8, 1'b0);
        winChk(-20'sh0_1388);
        drive(1'b1, 1'b0, 1'b1, -16'sh13EC, 16'h0000, 16'h0000);
        outChk(16'h044C, 1'b1);
        drive(1'b1, 1'b0, 1'b1, 16'h13EC, 16'h0000, 16'h0000);
        outChk(16'h0384, 1'b1);
    endtask

    task automatic t_analog;
        drive(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
        cfg(8'h01, 8'h01, 8'h1F, 8'h00, 8'h00);
        drive(1'b1, 1'b0, 1'b1, 16'h0C1C, 16'h07D0, 16'h03E8);
        outChk(16'h0384, 1'b1);
        winChk(20'h0_0000);
        drive(1'b1, 1'b0, 1'b1, 16'h0B54, 16'h07D0, 16'h03E8);
        outChk(16'h03E8, 1'b0);
        drive(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
        cfg(8'h01, 8'h01, 8'h01, 8'h00, 8'h00);
        drive(1'b1, 1'b0, 1'b1, 16'h0834, 16'h07D0, 16'h03E8);
        outChk(16'h0384, 1'b1);
        drive(1'b1, 1'b0, 1'b1, -16'sh0C1C, -16'sh0BB8, 16'h0000);
        outChk(16'h044C, 1'b1);
        winChk(-20'sh0_0BB8);
        drive(1'b1, 1'b0, 1'b1, -16'sh0064, -16'sh0BB8, 16'h0000);
        outChk(16'h03E8, 1'b0);
        drive(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
        cfg(8'h01, 8'h00, 8'h01, 8'h00, 8'h00);
        drive(1'b1, 1'b0, 1'b1, -16'sh0064, -16'sh0BB8, 16'h0000);
        outChk(16'h044C, 1'b1);
    endtask

    task automatic t_running;
        drive(1'b1, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
        bus(1'b1, OFS_MARGIN, 32'h0000_0014);
        regChk(OFS_MARGIN, 8'h00);
        bus(1'b1, OFS_SOURCE, 32'h0000_0002);
        regChk(OFS_SOURCE, 8'h01);
        bus(1'b1, OFS_LIMIT, 32'h0000_0005);
        refusedChk(1'b1);
        regChk(OFS_LIMIT, 8'h00);
        bus(1'b1, OFS_GAIN, 32'h0000_0020);
        regChk(OFS_GAIN, 8'h20);
        drive(1'b1, 1'b0, 1'b1, 16'h0064, 16'h0000, 16'h0000);
        outChk(16'h0320, 1'b1);
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_refuse();
        t_stored();
        t_margin();
        t_analog();
        t_running();
        end_of_test();
    end
endmodule
